// ===== inc/smbsl_pkg.sv
// How it works
// (R1) Only the seven-bit bus address 0101110 is answered.
// (R2) Master appends direction bit: 0x5C writes, 0x5D reads.
// (R3) Each byte is eight data bits plus one acknowledge bit.
// (R4) Data changes only while clock low; data rising with clock high is stop.
// (R5) Master ends a write with a stop on the tenth pulse.
// (R6) Master no-acknowledges a read byte, then stops; device releases data.
// (R7) Direction is fixed by the address byte until a new start.
// (R8) Writes carry one or two bytes; a read supplies exactly one byte.
// (R9) First byte after the address loads the register pointer.
// (R10) Second write byte is stored in the register the pointer selects.
// (R11) A pointer-only write changes no data register.
// (R12) A read returns the register selected by the pointer.
// (R13) The pointer is kept between transfers.
// (R14) Repeated start is accepted in place of stop.
// (R15) Send byte: address and command code are both acknowledged.
// (R16) Pointer write then repeated start read returns that register.
// (R17) Monitoring enable, bit 0 of 0x40, stays writable when locked.
// (R18) After 35 ms bus inactivity the device releases the bus.
// (R19) Bit 6 of 0x40 set disables the bus timeout; default 0.
// (R20) A non-matching address is not acknowledged; transfer ignored until start.
package smbsl_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h2E;
   localparam logic [7:0] MAIN_CFG_OFS = 8'h40;
   localparam logic [7:0] MAIN_CFG_RESET = 8'h01;
   localparam int MON_EN_BIT = 0;
   localparam int LOCK_BIT = 1;
   localparam int BUS_TIMEOUT_OFF_BIT = 6;
   localparam int CLK_HZ = 25000000;
   localparam int TIMEOUT_MS = 35;
   localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
   localparam int REG_COUNT = 256;
   typedef enum logic [2:0] {
      SMBSL_IDLE, SMBSL_ADDR, SMBSL_RXDATA, SMBSL_TXDATA, SMBSL_ACK, SMBSL_MACK
   } smbsl_state_t;
endpackage

// ===== inc/smbsl_line_if.sv
`timescale 1ns/10ps
// Conditioned bus events passed from the line watcher to the protocol engine
interface smbsl_line_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_in;
   logic start;
   logic stop;
   logic idle_timeout;
   modport watcher(output scl_rise, scl_fall, sda_in, start, stop, idle_timeout);
   modport engine(input scl_rise, scl_fall, sda_in, start, stop, idle_timeout);
endinterface

// ===== logic/smbsl_line_watch.sv
`timescale 1ns/10ps
module smbsl_line_watch #(
   parameter int TIMEOUT_CYCLES = smbsl_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Bus lines and control
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_timeout_off,
   // Events
   smbsl_line_if.watcher line
);
   logic scl_reg;
   logic sda_reg;
   logic [31:0] idle_cnt_reg;
   logic timed_out_reg;
   wire activity = (i_scl != scl_reg) || (i_sda != sda_reg);
   assign line.scl_rise = i_scl && !scl_reg;
   assign line.scl_fall = !i_scl && scl_reg;
   assign line.sda_in = i_sda;
   assign line.start = i_scl && scl_reg && sda_reg && !i_sda;
   assign line.stop = i_scl && scl_reg && !sda_reg && i_sda; // [R4]
   assign line.idle_timeout = timed_out_reg;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         idle_cnt_reg <= 32'h0;
         timed_out_reg <= 1'b0;
      end else begin
         scl_reg <= i_scl;
         sda_reg <= i_sda;
         timed_out_reg <= 1'b0;
         if (activity || i_timeout_off) begin // [R19]
            idle_cnt_reg <= 32'h0;
         end else if (idle_cnt_reg == 32'(TIMEOUT_CYCLES - 1)) begin
            idle_cnt_reg <= 32'h0;
            timed_out_reg <= 1'b1; // [R18]
         end else begin
            idle_cnt_reg <= idle_cnt_reg + 32'h1;
         end
      end
   end
endmodule

// ===== logic/smbsl_slave.sv
`timescale 1ns/10ps
module smbsl_slave #(
   parameter int TIMEOUT_CYCLES = smbsl_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Bus pins, data open drain
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   // Device register access
   output logic [7:0] o_pointer,
   output logic [7:0] o_main_cfg,
   output logic o_reg_wr,
   output logic [7:0] o_reg_wr_data,
   input wire logic [7:0] i_reg_rd_data
);
   smbsl_line_if line();
   smbsl_pkg::smbsl_state_t state_reg;
   smbsl_pkg::smbsl_state_t state_next;
   smbsl_pkg::smbsl_state_t after_ack_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [1:0] byte_cnt_reg;
   logic rd_dir_reg;
   logic drive_low_reg;
   logic [7:0] pointer_reg;
   logic [7:0] cfg_reg;
   logic wr_reg;
   logic [7:0] wr_data_reg;

   smbsl_line_watch #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_smbsl_line_watch (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .i_timeout_off(cfg_reg[smbsl_pkg::BUS_TIMEOUT_OFF_BIT]),
      .line(line)
   );

   wire [7:0] rx_byte = {shift_reg[6:0], line.sda_in};
   wire byte_done = line.scl_rise && (bit_cnt_reg == 4'd7); // [R3]
   wire addr_hit = (rx_byte[7:1] == smbsl_pkg::DEV_ADDR); // [R1]
   wire cfg_sel = (pointer_reg == smbsl_pkg::MAIN_CFG_OFS);
   wire locked = cfg_reg[smbsl_pkg::LOCK_BIT];
   // When locked only monitoring enable may change
   wire [7:0] cfg_wr_val = locked ?
      {cfg_reg[7:1], rx_byte[smbsl_pkg::MON_EN_BIT]} : rx_byte; // [R17]
   wire [7:0] tx_src = cfg_sel ? cfg_reg : i_reg_rd_data; // [R12]

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         smbsl_pkg::SMBSL_IDLE: state_next = smbsl_pkg::SMBSL_IDLE;
         smbsl_pkg::SMBSL_ADDR: begin
            if (byte_done) begin
               // Foreign address: stay silent until next start
               state_next = addr_hit ? smbsl_pkg::SMBSL_ACK : smbsl_pkg::SMBSL_IDLE; // [R20]
            end
         end
         smbsl_pkg::SMBSL_RXDATA: begin
            if (byte_done) begin
               state_next = smbsl_pkg::SMBSL_ACK;
            end
         end
         smbsl_pkg::SMBSL_TXDATA: begin
            if (line.scl_fall && bit_cnt_reg == 4'd8) begin
               state_next = smbsl_pkg::SMBSL_MACK;
            end
         end
         smbsl_pkg::SMBSL_ACK: begin
            // Leave on the fall that ends the ninth clock, after the ack was pulled
            if (line.scl_fall && drive_low_reg) begin
               state_next = after_ack_reg;
            end
         end
         smbsl_pkg::SMBSL_MACK: begin
            // One byte per read; after master answer wait for stop
            if (line.scl_rise) begin
               state_next = smbsl_pkg::SMBSL_IDLE; // [R8]
            end
         end
         default: state_next = smbsl_pkg::SMBSL_IDLE;
      endcase
      if (line.start) begin
         state_next = smbsl_pkg::SMBSL_ADDR; // [R14]
      end
      if (line.stop || line.idle_timeout) begin
         state_next = smbsl_pkg::SMBSL_IDLE; // [R18]
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_reg <= smbsl_pkg::SMBSL_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Bit and byte framing
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'd0;
         byte_cnt_reg <= 2'd0;
         rd_dir_reg <= 1'b0;
         after_ack_reg <= smbsl_pkg::SMBSL_IDLE;
      end else if (line.start) begin
         bit_cnt_reg <= 4'd0;
         byte_cnt_reg <= 2'd0;
      end else if (line.scl_rise && (state_reg == smbsl_pkg::SMBSL_ADDR ||
                                      state_reg == smbsl_pkg::SMBSL_RXDATA)) begin
         shift_reg <= rx_byte;
         bit_cnt_reg <= bit_cnt_reg + 4'd1;
         if (byte_done && state_reg == smbsl_pkg::SMBSL_ADDR) begin
            rd_dir_reg <= line.sda_in; // [R7]
            after_ack_reg <= line.sda_in ? smbsl_pkg::SMBSL_TXDATA : smbsl_pkg::SMBSL_RXDATA;
         end else if (byte_done) begin
            byte_cnt_reg <= (byte_cnt_reg == 2'd2) ? 2'd2 : byte_cnt_reg + 2'd1;
            after_ack_reg <= smbsl_pkg::SMBSL_RXDATA;
         end
      end else if (state_reg == smbsl_pkg::SMBSL_ACK && line.scl_fall && drive_low_reg) begin
         bit_cnt_reg <= 4'd0;
         if (rd_dir_reg) begin
            shift_reg <= tx_src; // [R12]
         end
      end else if (state_reg == smbsl_pkg::SMBSL_TXDATA && line.scl_fall) begin
         bit_cnt_reg <= bit_cnt_reg + 4'd1;
         shift_reg <= {shift_reg[6:0], 1'b1};
      end
   end

   // Acknowledge and read data drive, set only on clock fall; start, stop or timeout release it
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || line.stop || line.idle_timeout || line.start) begin
         drive_low_reg <= 1'b0;
      end else if (line.scl_fall) begin
         if (state_reg == smbsl_pkg::SMBSL_ACK) begin
            // First fall pulls the ack; second hands over to the read MSB or releases
            drive_low_reg <= !drive_low_reg || (rd_dir_reg && !tx_src[7]); // [R15]
         end else if (state_reg == smbsl_pkg::SMBSL_TXDATA) begin
            // Next bit is the one below the bit just clocked out; free the line for the NAK
            drive_low_reg <= (bit_cnt_reg < 4'd7) && !shift_reg[6]; // [R4]
         end else begin
            drive_low_reg <= 1'b0; // [R6]
         end
      end
   end

   // Pointer and register stores
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         pointer_reg <= 8'h00;
         cfg_reg <= smbsl_pkg::MAIN_CFG_RESET;
         wr_reg <= 1'b0;
         wr_data_reg <= 8'h00;
      end else begin
         wr_reg <= 1'b0;
         if (byte_done && state_reg == smbsl_pkg::SMBSL_RXDATA) begin
            if (byte_cnt_reg == 2'd0) begin
               pointer_reg <= rx_byte; // [R9] [R11] [R13] [R16]
            end else if (byte_cnt_reg == 2'd1) begin
               wr_data_reg <= rx_byte; // [R10]
               wr_reg <= !cfg_sel;
               if (cfg_sel) begin
                  cfg_reg <= cfg_wr_val;
               end
            end
         end
      end
   end

   // Open drain: the pin is only ever pulled low, never driven high
   always_comb begin
      o_sda = 1'b0;
      o_sda_oe_n = !drive_low_reg;
   end

   assign o_pointer = pointer_reg;
   assign o_main_cfg = cfg_reg;
   assign o_reg_wr = wr_reg;
   assign o_reg_wr_data = wr_data_reg;
endmodule

// ===== tb/smbsl_slave_props.sv
`timescale 1ns/10ps
module smbsl_slave_props #(
   parameter int TIMEOUT_CYCLES = 200
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Watched pins
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe_n,
   input wire logic [7:0] o_pointer,
   input wire logic [7:0] o_main_cfg,
   input wire logic o_reg_wr
);
   int idle_cnt;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // Saturates so a long quiet bus cannot wrap the count
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || $changed(i_scl) || $changed(i_sda)) idle_cnt <= 0;
      else if (idle_cnt < TIMEOUT_CYCLES + 16) idle_cnt <= idle_cnt + 1;
   end
   property p_oe_fall; $fell(o_sda_oe_n) |-> !i_scl; endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("Drive began with clock high");
   property p_hold; i_scl && $past(i_scl) |-> $stable(o_sda_oe_n); endproperty
   a_hold: assert property (p_hold) else $error("Data moved with clock high");
   property p_sda_zero; o_sda == 1'b0; endproperty
   a_sda_zero: assert property (p_sda_zero) else $error("Data driven high");
   property p_drive_low; !o_sda_oe_n |-> !i_sda; endproperty
   a_drive_low: assert property (p_drive_low) else $error("Driven line not low");
   property p_wr_pulse; o_reg_wr |=> !o_reg_wr; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("Write strobe too long");
   property p_wr_ptr; o_reg_wr |-> o_pointer != 8'h40; endproperty
   a_wr_ptr: assert property (p_wr_ptr) else $error("Config sent outside");
   property p_lock; o_main_cfg[1] |=> $stable(o_main_cfg[7:1]); endproperty
   a_lock: assert property (p_lock) else $error("Locked config changed");
   property p_tmo; idle_cnt >= TIMEOUT_CYCLES + 8 && !o_main_cfg[6] |-> o_sda_oe_n; endproperty
   a_tmo: assert property (p_tmo) else $error("Hung bus not released");
   c_wr: cover property (o_reg_wr);
   c_ack: cover property ($fell(o_sda_oe_n));
   c_lock: cover property ($rose(o_main_cfg[1]));
endmodule

// ===== tb/smbsl_master_model.sv
`timescale 1ns/10ps
module smbsl_master_model (
   // Clock
   input wire logic i_sys_clk,
   // Bus
   input wire logic i_sda,
   output logic o_scl = 1'b1,
   output logic o_sda = 1'b1
);
   // Four cycles a phase keeps the slave's sampling well inside each level
   task automatic drv(input logic c, input logic d);
      o_scl <= c;
      o_sda <= d;
      repeat (4) @(posedge i_sys_clk);
   endtask
   task automatic start;
      drv(o_scl, 1'b1);
      drv(1'b1, 1'b1);
      drv(1'b1, 1'b0);
      drv(1'b0, 1'b0);
   endtask
   task automatic stop;
      drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      drv(1'b1, 1'b1);
   endtask
   task automatic bitx(input logic b, output logic r);
      drv(1'b0, b);
      drv(1'b1, b);
      r = i_sda;
      drv(1'b0, b);
   endtask
   // A data bit of 1 releases the line so the slave may drive it
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
      output logic a);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(ack_in, a);
   endtask
endmodule

// ===== tb/smbsl_slave_bench.sv
`timescale 1ns/10ps
module smbsl_slave_bench;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic m_scl, m_sda, a, o_sda, o_sda_oe_n, o_reg_wr;
   logic [7:0] q, o_pointer, o_main_cfg, o_reg_wr_data;
   logic [7:0] mem [256];
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   // Pulled-up wire: low whenever either side pulls
   wire sda_w = m_sda & (o_sda_oe_n | o_sda);
   always #20 i_sys_clk = ~i_sys_clk;
   smbsl_master_model i_smbsl_master_model (.i_sys_clk(i_sys_clk), .i_sda(sda_w),
      .o_scl(m_scl), .o_sda(m_sda));
   smbsl_slave #(.TIMEOUT_CYCLES(200)) i_smbsl_slave (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_scl(m_scl), .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
      .o_pointer(o_pointer), .o_main_cfg(o_main_cfg), .o_reg_wr(o_reg_wr),
      .o_reg_wr_data(o_reg_wr_data), .i_reg_rd_data(mem[o_pointer]));
   task automatic final_report;
      $display("errors %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (o_reg_wr) mem[o_pointer] <= o_reg_wr_data;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic two, input logic stp);
      i_smbsl_master_model.start();
      i_smbsl_master_model.xfer(8'h5C, 1'b1, q, a);
      chk({7'h00, a}, 8'h00, "address ack");
      i_smbsl_master_model.xfer(p, 1'b1, q, a);
      chk({7'h00, a}, 8'h00, "pointer ack");
      if (two) begin
         i_smbsl_master_model.xfer(d, 1'b1, q, a);
         chk({7'h00, a}, 8'h00, "data ack");
      end
      if (stp) i_smbsl_master_model.stop();
   endtask
   task automatic rd(output logic [7:0] v);
      i_smbsl_master_model.start();
      i_smbsl_master_model.xfer(8'h5D, 1'b1, q, a);
      chk({7'h00, a}, 8'h00, "read ack");
      i_smbsl_master_model.xfer(8'hFF, 1'b1, v, a);
      i_smbsl_master_model.stop();
   endtask
   // Leaves the slave driving its address ack with the clock parked low
   task automatic stall(input logic e);
      q = 8'h5C;
      i_smbsl_master_model.start();
      for (int i = 7; i >= 0; i--) i_smbsl_master_model.bitx(q[i], a);
      repeat (250) @(posedge i_sys_clk);
      chk({7'h00, o_sda_oe_n}, {7'h00, e}, "release");
      i_smbsl_master_model.bitx(1'b1, a);
      i_smbsl_master_model.stop();
   endtask
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(~i);
      repeat (16) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      @(posedge i_sys_clk);
      chk(o_main_cfg, 8'h01, "cfg reset");
      wr(8'h10, 8'hA5, 1'b1, 1'b1);
      chk(o_pointer, 8'h10, "pointer");
      chk(mem[8'h10], 8'hA5, "stored");
      rd(q);
      chk(q, 8'hA5, "read");
      wr(8'h20, 8'h00, 1'b0, 1'b0);
      rd(q);
      chk(q, 8'hDF, "chained read");
      i_smbsl_master_model.start();
      i_smbsl_master_model.xfer(8'h5E, 1'b1, q, a);
      chk({7'h00, a}, 8'h01, "foreign ack");
      i_smbsl_master_model.xfer(8'h30, 1'b1, q, a);
      i_smbsl_master_model.stop();
      chk(o_pointer, 8'h20, "foreign pointer");
      wr(8'h40, 8'h41, 1'b1, 1'b1);
      chk(o_main_cfg, 8'h41, "cfg");
      stall(1'b0);
      wr(8'h40, 8'h01, 1'b1, 1'b1);
      stall(1'b1);
      wr(8'h40, 8'h02, 1'b1, 1'b1);
      wr(8'h40, 8'hC1, 1'b1, 1'b1);
      chk(o_main_cfg, 8'h03, "locked cfg");
      rd(q);
      chk(q, 8'h03, "cfg read");
      final_report();
   end
endmodule
bind smbsl_slave smbsl_slave_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_smbsl_slave_props (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
   .o_sda_oe_n(o_sda_oe_n), .o_pointer(o_pointer), .o_main_cfg(o_main_cfg),
   .o_reg_wr(o_reg_wr));
